// ---- design/timer_pair_pkg.sv ----
package timer_pair_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int ADDR_W = 16;
  localparam int DIV_W = 8;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] LOW_COUNT_ADDR = 16'h0106;
  localparam logic [ADDR_W-1:0] HOLDING_ADDR = 16'h0108;
  localparam logic [ADDR_W-1:0] HIGH_COUNT_ADDR = 16'h010a;
  localparam logic [ADDR_W-1:0] PERIOD_LOW_ADDR = 16'h010c;
  localparam logic [ADDR_W-1:0] PERIOD_HIGH_ADDR = 16'h010e;
  localparam logic [ADDR_W-1:0] LOW_CTRL_ADDR = 16'h0110;
  localparam logic [ADDR_W-1:0] HIGH_CTRL_ADDR = 16'h0112;
  localparam logic [ADDR_W-1:0] IRQ_FLAG_ADDR = 16'h0114;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = 16'h0116;

  // ------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------
  localparam int RUN_BIT = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int GATE_BIT = 6;
  localparam int DIV_HI_BIT = 5;
  localparam int DIV_LO_BIT = 4;
  localparam int WIDE_BIT = 3;
  localparam int SRC_BIT = 1;
  localparam logic [WORD_W-1:0] LOW_CTRL_MASK = 16'ha07a;
  localparam logic [WORD_W-1:0] HIGH_CTRL_MASK = 16'ha072;
  localparam int LOW_FLAG_BIT = 0;
  localparam int HIGH_FLAG_BIT = 1;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [WORD_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] PERIOD_RESET = 16'hffff;
  localparam logic [WORD_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_ONES = 16'hffff;
  localparam logic [WORD_W-1:0] WORD_ONE = 16'h0001;

  // ------------------------------------------------------------
  // Prescaler terminal counts (divide minus one)
  // ------------------------------------------------------------
  localparam logic [1:0] DIV_SEL_1 = 2'h0;
  localparam logic [1:0] DIV_SEL_8 = 2'h1;
  localparam logic [1:0] DIV_SEL_64 = 2'h2;
  localparam logic [DIV_W-1:0] TERM_1 = 8'h00;
  localparam logic [DIV_W-1:0] TERM_8 = 8'h07;
  localparam logic [DIV_W-1:0] TERM_64 = 8'h3f;
  localparam logic [DIV_W-1:0] TERM_256 = 8'hff;
  localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;

  // ------------------------------------------------------------
  // Clock
  // ------------------------------------------------------------
  localparam int CLK_HZ = 20000000;

endpackage

// ---- design/input_divider.sv ----
`timescale 1ns/100ps
module input_divider (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clear_i,
  input wire logic [1:0] sel_i,
  // Ticks
  input wire logic tick_i,
  output logic tick_o
);
  import timer_pair_pkg::*;

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] term;

  always_comb begin
    case (sel_i)
      DIV_SEL_1: term = TERM_1;
      DIV_SEL_8: term = TERM_8;
      DIV_SEL_64: term = TERM_64;
      default: term = TERM_256;
    endcase
  end

  // A halted input tick freezes the counter as well
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      count <= TERM_1;
    end else if (tick_i) begin
      count <= (count == term) ? TERM_1 : count + DIV_ONE;
    end
  end

  assign tick_o = tick_i && (count == term);

  property p_div_clear;
    @(posedge clk_i) disable iff (rst_i)
      clear_i |=> count == TERM_1;
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("divider not cleared");

endmodule

// ---- design/timer_pair.sv ----
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
module timer_pair (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [timer_pair_pkg::ADDR_W-1:0] addr_i,
  input wire logic [timer_pair_pkg::WORD_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [timer_pair_pkg::WORD_W-1:0] rdata_o,
  // Processor power state
  input wire logic idle_i,
  input wire logic sleep_i,
  // External clock and gate pins
  input wire logic external_clock_gate_pin_i,
  input wire logic high_clock_pin_i,
  // Events
  output logic low_irq_o,
  output logic high_irq_o,
  output logic adc_trigger_o,
  // Timebase for capture and compare
  output logic [timer_pair_pkg::WORD_W-1:0] low_count_o,
  output logic [timer_pair_pkg::WORD_W-1:0] high_count_o,
  output logic low_match_o,
  output logic high_match_o
);
  import timer_pair_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [WORD_W-1:0] low_count_word;
  logic [WORD_W-1:0] high_count_word;
  logic [WORD_W-1:0] high_word_holding;
  logic [WORD_W-1:0] period_low_word;
  logic [WORD_W-1:0] period_high_word;
  logic [WORD_W-1:0] low_timer_control;
  logic [WORD_W-1:0] high_timer_control;
  logic low_flag;
  logic high_timer_irq_flag;
  logic low_enable;
  logic high_timer_irq_enable;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] sync3;
  logic [1:0] pin_level;
  logic [1:0] pin_prev;
  logic low_tick;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // A pin level only counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      sync3 <= 2'h0;
      pin_level <= 2'h0;
      pin_prev <= 2'h0;
    end else begin
      sync1 <= {high_clock_pin_i, external_clock_gate_pin_i};
      sync2 <= sync1;
      sync3 <= sync2;
      pin_level <= (sync2 & ~(sync2 ^ sync3)) | (pin_level & (sync2 ^ sync3));
      pin_prev <= pin_level;
    end
  end

  logic low_pin_rise;
  logic high_pin_rise;
  logic gate_fall;
  assign low_pin_rise = pin_level[0] && !pin_prev[0];
  assign high_pin_rise = pin_level[1] && !pin_prev[1];

  // ------------------------------------------------------------
  // Effective configuration
  // ------------------------------------------------------------
  logic wide;
  logic low_run;
  logic high_run;
  logic low_gated;
  logic low_counting;
  logic high_counting;
  assign wide = low_timer_control[WIDE_BIT];
  assign low_run = low_timer_control[RUN_BIT];
  assign high_run = high_timer_control[RUN_BIT];
  // Gate mode only with internal source; high gate bit never looked at
  assign low_gated = low_timer_control[GATE_BIT] && !low_timer_control[SRC_BIT];
  assign low_counting = low_run && !sleep_i &&
                        !(idle_i && low_timer_control[IDLE_STOP_BIT]);
  assign high_counting = high_run && !sleep_i &&
                         !(idle_i && high_timer_control[IDLE_STOP_BIT]);
  assign gate_fall = low_run && low_gated && pin_level[0] == 1'b0 && pin_prev[0];

  // ------------------------------------------------------------
  // Tick sources and prescalers
  // ------------------------------------------------------------
  logic low_src;
  logic high_src;
  logic low_pre_tick;
  logic high_tick;
  logic count_write;
  logic run_clear;
  always_comb begin
    if (low_timer_control[SRC_BIT]) begin
      low_src = low_pin_rise;
    end else if (low_gated) begin
      low_src = pin_level[0];
    end else begin
      low_src = 1'b1;
    end
  end
  // In combined mode the high prescaler never sees a tick
  assign high_src = !wide && high_counting &&
                    (high_timer_control[SRC_BIT] ? high_pin_rise : 1'b1);

  assign count_write = we_i && (addr_i == LOW_COUNT_ADDR || addr_i == HIGH_COUNT_ADDR);
  assign run_clear = we_i && !wdata_i[RUN_BIT] &&
                     ((addr_i == LOW_CTRL_ADDR && low_run) ||
                      (addr_i == HIGH_CTRL_ADDR && high_run));

  input_divider low_divider (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(low_run && (count_write || run_clear)),
    .sel_i(low_timer_control[DIV_HI_BIT:DIV_LO_BIT]),
    .tick_i(low_src && low_counting),
    .tick_o(low_pre_tick)
  );

  input_divider high_divider (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(count_write || run_clear),
    .sel_i(high_timer_control[DIV_HI_BIT:DIV_LO_BIT]),
    .tick_i(high_src),
    .tick_o(high_tick)
  );

  // Extra stage on the low path only; costs one cycle of latency
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_tick <= 1'b0;
    end else begin
      low_tick <= low_pre_tick && low_counting;
    end
  end

  // ------------------------------------------------------------
  // Counters
  // ------------------------------------------------------------
  logic wide_match;
  logic low_match16;
  logic high_match16;
  logic low_event;
  logic high_event;
  logic low_wr;
  logic high_wr;
  assign wide_match = {high_count_word, low_count_word} ==
                      {period_high_word, period_low_word};
  assign low_match16 = low_count_word == period_low_word;
  assign high_match16 = high_count_word == period_high_word;
  assign low_event = !wide && low_tick && low_match16;
  assign high_event = wide ? (low_tick && wide_match) : (high_tick && high_match16);
  assign low_wr = we_i && addr_i == LOW_COUNT_ADDR;
  assign high_wr = we_i && addr_i == HIGH_COUNT_ADDR;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_count_word <= COUNT_RESET;
    end else if (low_wr) begin
      low_count_word <= wdata_i;
    end else if (low_tick) begin
      if (wide ? wide_match : low_match16) begin
        low_count_word <= COUNT_RESET;
      end else begin
        low_count_word <= low_count_word + WORD_ONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_count_word <= COUNT_RESET;
    end else if (low_wr && wide) begin
      high_count_word <= high_word_holding;
    end else if (high_wr) begin
      high_count_word <= wdata_i;
    end else if (wide && low_tick) begin
      if (wide_match) begin
        high_count_word <= COUNT_RESET;
      end else if (low_count_word == WORD_ONES) begin
        high_count_word <= high_count_word + WORD_ONE;
      end
    end else if (!wide && high_tick) begin
      high_count_word <= high_match16 ? COUNT_RESET : high_count_word + WORD_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_word_holding <= COUNT_RESET;
    end else if (re_i && addr_i == LOW_COUNT_ADDR) begin
      high_word_holding <= high_count_word;
    end else if (we_i && addr_i == HOLDING_ADDR) begin
      high_word_holding <= wdata_i;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_low_word <= PERIOD_RESET;
      period_high_word <= PERIOD_RESET;
      low_timer_control <= CTRL_RESET;
      high_timer_control <= CTRL_RESET;
      low_enable <= 1'b0;
      high_timer_irq_enable <= 1'b0;
    end else if (we_i) begin
      case (addr_i)
        PERIOD_LOW_ADDR: period_low_word <= wdata_i;
        PERIOD_HIGH_ADDR: period_high_word <= wdata_i;
        LOW_CTRL_ADDR: low_timer_control <= wdata_i & LOW_CTRL_MASK;
        HIGH_CTRL_ADDR: high_timer_control <= wdata_i & HIGH_CTRL_MASK;
        IRQ_ENABLE_ADDR: begin
          low_enable <= wdata_i[LOW_FLAG_BIT];
          high_timer_irq_enable <= wdata_i[HIGH_FLAG_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Sticky event flags, write one to clear, set wins
  // ------------------------------------------------------------
  logic flag_clear;
  assign flag_clear = we_i && addr_i == IRQ_FLAG_ADDR;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_flag <= 1'b0;
    end else if (low_event || (!wide && gate_fall)) begin
      low_flag <= 1'b1;
    end else if (flag_clear && wdata_i[LOW_FLAG_BIT]) begin
      low_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_timer_irq_flag <= 1'b0;
    end else if (high_event || (wide && gate_fall)) begin
      high_timer_irq_flag <= 1'b1;
    end else if (flag_clear && wdata_i[HIGH_FLAG_BIT]) begin
      high_timer_irq_flag <= 1'b0;
    end
  end

  assign low_irq_o = low_flag && low_enable;
  assign high_irq_o = high_timer_irq_flag && high_timer_irq_enable;

  // ------------------------------------------------------------
  // Event and timebase outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_trigger_o <= 1'b0;
      low_match_o <= 1'b0;
      high_match_o <= 1'b0;
    end else begin
      adc_trigger_o <= high_event;
      low_match_o <= low_event;
      high_match_o <= high_event;
    end
  end

  assign low_count_o = low_count_word;
  assign high_count_o = high_count_word;

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !re_i) begin
      rdata_o <= COUNT_RESET;
    end else begin
      case (addr_i)
        LOW_COUNT_ADDR: rdata_o <= low_count_word;
        HOLDING_ADDR: rdata_o <= high_word_holding;
        HIGH_COUNT_ADDR: rdata_o <= high_count_word;
        PERIOD_LOW_ADDR: rdata_o <= period_low_word;
        PERIOD_HIGH_ADDR: rdata_o <= period_high_word;
        LOW_CTRL_ADDR: rdata_o <= low_timer_control;
        HIGH_CTRL_ADDR: rdata_o <= high_timer_control;
        IRQ_FLAG_ADDR: rdata_o <= {14'h0000, high_timer_irq_flag, low_flag};
        IRQ_ENABLE_ADDR: rdata_o <= {14'h0000, high_timer_irq_enable, low_enable};
        default: rdata_o <= COUNT_RESET;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_wrap16;
    @(posedge clk_i) disable iff (rst_i)
      !wide && low_tick && low_match16 && !low_wr |=> low_count_word == COUNT_RESET;
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("low timer did not wrap");

  property p_inc32;
    @(posedge clk_i) disable iff (rst_i)
      wide && low_tick && !wide_match && !low_wr && !high_wr
      |=> {high_count_word, low_count_word} ==
          $past({high_count_word, low_count_word}) + 32'h00000001;
  endproperty
  a_inc32: assert property (p_inc32) else $error("combined count did not step");

  property p_capture;
    @(posedge clk_i) disable iff (rst_i)
      re_i && addr_i == LOW_COUNT_ADDR |=> high_word_holding == $past(high_count_word);
  endproperty
  a_capture: assert property (p_capture) else $error("holding not captured");

  property p_coherent_write;
    @(posedge clk_i) disable iff (rst_i)
      low_wr && wide |=> high_count_word == $past(high_word_holding) &&
                         low_count_word == $past(wdata_i);
  endproperty
  a_coherent_write: assert property (p_coherent_write) else $error("bad 32-bit write");

  property p_ctrl_write;
    @(posedge clk_i) disable iff (rst_i)
      we_i && (addr_i == LOW_CTRL_ADDR) && !low_tick |=> $stable(low_count_word);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write moved count");

  property p_sleep;
    @(posedge clk_i) disable iff (rst_i)
      sleep_i ##1 sleep_i |-> !low_tick && !high_tick;
  endproperty
  a_sleep: assert property (p_sleep) else $error("counting during sleep");

  property p_idle;
    @(posedge clk_i) disable iff (rst_i)
      (idle_i && low_timer_control[IDLE_STOP_BIT]) [*2] |-> !low_tick;
  endproperty
  a_idle: assert property (p_idle) else $error("counting during idle stop");

  property p_sticky;
    @(posedge clk_i) disable iff (rst_i)
      high_timer_irq_flag && !(flag_clear && wdata_i[HIGH_FLAG_BIT]) |=> high_timer_irq_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("high flag dropped");

  property p_adc;
    @(posedge clk_i) disable iff (rst_i)
      wide && low_tick && wide_match |=> adc_trigger_o ##1 !adc_trigger_o || high_event;
  endproperty
  a_adc: assert property (p_adc) else $error("trigger not one pulse");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
      wide && high_event ##1 high_timer_irq_enable |-> high_irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("combined interrupt missing");

endmodule

// ---- verification/pin_source.sv ----
`timescale 1ns/100ps
module pin_source (
  // Clock
  input wire logic clk_i,
  // Pin
  output logic pin_o
);
  initial pin_o = 1'b0;

  // ----------------------------------------
  // Gate window
  // ----------------------------------------
  task automatic gate_window(input int cycles);
    @(posedge clk_i);
    pin_o <= 1'b1;
    repeat (cycles) @(posedge clk_i);
    pin_o <= 1'b0;
  endtask

  // ----------------------------------------
  // Clock burst
  // ----------------------------------------
  // Held low between bursts, so no stray edge
  task automatic clock_burst(input int edges, input int half);
    repeat (edges) begin
      @(posedge clk_i);
      pin_o <= 1'b1;
      repeat (half) @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (half) @(posedge clk_i);
    end
  endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import timer_pair_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = 16'h0000;
  logic [WORD_W-1:0] wdata_i = 16'h0000;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic idle_i = 1'b0;
  logic sleep_i = 1'b0;
  logic pin;
  logic [WORD_W-1:0] rdata_o, low_count_o, high_count_o, c1;
  logic low_irq_o, high_irq_o, adc_trigger_o, low_match_o, high_match_o, seen, bad;
  logic [WORD_W-1:0] divs [4] = '{16'h0001, 16'h0008, 16'h0040, 16'h0100};
  int fails = 0;
  int check_count = 0;
  int n1, n2;

  always #25 clk_i = ~clk_i;

  pin_source ext (.clk_i(clk_i), .pin_o(pin));
  timer_pair uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .idle_i(idle_i), .sleep_i(sleep_i),
    .external_clock_gate_pin_i(pin), .high_clock_pin_i(pin), .low_irq_o(low_irq_o),
    .high_irq_o(high_irq_o), .adc_trigger_o(adc_trigger_o), .low_count_o(low_count_o),
    .high_count_o(high_count_o), .low_match_o(low_match_o), .high_match_o(high_match_o));

  // ----------------------------------------
  // Access and compare
  // ----------------------------------------
  task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp,
                       input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] exp, input string what);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    check(rdata_o, exp, what);
  endtask

  task automatic wait_low(input logic [WORD_W-1:0] v, output int n);
    n = 0;
    while (low_count_o !== v && n < 2000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 2000) check(low_count_o, v, "count wait");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // Whole sequence needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    complete_run();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(PERIOD_LOW_ADDR, 16'hffff, "period reset");
    rd(LOW_CTRL_ADDR, 16'h0000, "control reset");
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      wr(LOW_CTRL_ADDR, 16'h0000);
      wr(LOW_COUNT_ADDR, 16'h0000);
      wr(LOW_CTRL_ADDR, {8'h80, 2'h0, s[1:0], 4'h0});
      wait_low(16'h0001, n1);
      wait_low(16'h0002, n2);
      check(16'(n2), divs[s], "divider step");
    end
    $display("test divider done");
    for (int k = 0; k < 3; k++) begin
      wr(LOW_CTRL_ADDR, 16'h0000);
      wr(LOW_COUNT_ADDR, 16'h0000);
      idle_i <= (k < 2);
      sleep_i <= (k == 2);
      wr(LOW_CTRL_ADDR, (k == 0) ? 16'ha000 : 16'h8000);
      repeat (20) @(posedge clk_i);
      check({15'h0000, low_count_o !== 16'h0000}, {15'h0000, k == 1}, "power hold");
      idle_i <= 1'b0;
      sleep_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      check({15'h0000, low_count_o !== 16'h0000}, 16'h0001, "power resume");
    end
    $display("test power done");
    wr(PERIOD_LOW_ADDR, 16'h0002);
    wr(IRQ_ENABLE_ADDR, 16'h0001);
    wr(LOW_COUNT_ADDR, 16'h0000);
    seen = 1'b0;
    bad = 1'b0;
    repeat (20) begin
      @(posedge clk_i);
      #1;
      seen |= low_match_o;
      bad |= (low_count_o > 16'h0002);
    end
    check({14'h0000, seen, bad}, 16'h0002, "16-bit wrap");
    check({15'h0000, low_irq_o}, 16'h0001, "low event");
    $display("test 16-bit done");
    wr(LOW_CTRL_ADDR, 16'h0008);
    wr(HOLDING_ADDR, 16'h1234);
    wr(LOW_COUNT_ADDR, 16'h5678);
    wr(HOLDING_ADDR, 16'h0000);
    wr(LOW_CTRL_ADDR, 16'h0028);
    rd(LOW_COUNT_ADDR, 16'h5678, "low word");
    rd(HOLDING_ADDR, 16'h1234, "holding capture");
    rd(HIGH_COUNT_ADDR, 16'h1234, "high word");
    $display("test coherent done");
    wr(PERIOD_LOW_ADDR, 16'h0003);
    wr(PERIOD_HIGH_ADDR, 16'h0001);
    wr(HIGH_CTRL_ADDR, 16'h8030);
    wr(HOLDING_ADDR, 16'h0001);
    wr(LOW_COUNT_ADDR, 16'h0000);
    #1;
    check(high_count_o, 16'h0001, "high load");
    wr(IRQ_FLAG_ADDR, 16'h0003);
    wr(IRQ_ENABLE_ADDR, 16'h0002);
    wr(LOW_CTRL_ADDR, 16'h8008);
    n1 = 0;
    while (adc_trigger_o !== 1'b1 && n1 < 50) begin
      @(posedge clk_i);
      #1;
      n1++;
    end
    check({15'h0000, adc_trigger_o}, 16'h0001, "trigger");
    check(high_count_o, 16'h0000, "combined wrap");
    check({15'h0000, high_match_o}, 16'h0001, "combined match out");
    repeat (2) @(posedge clk_i);
    check({15'h0000, high_irq_o}, 16'h0001, "combined event");
    wr(LOW_CTRL_ADDR, 16'h0008);
    wr(IRQ_FLAG_ADDR, 16'h0002);
    #1;
    check({15'h0000, high_irq_o}, 16'h0000, "flag cleared");
    $display("test combined done");
    wr(PERIOD_LOW_ADDR, 16'h0004);
    wr(PERIOD_HIGH_ADDR, 16'h0000);
    wr(HOLDING_ADDR, 16'h0000);
    wr(LOW_COUNT_ADDR, 16'h0000);
    wr(LOW_CTRL_ADDR, 16'h800a);
    ext.clock_burst(7, 6);
    repeat (20) @(posedge clk_i);
    check(low_count_o, 16'h0002, "edge count");
    $display("test counter done");
    wr(LOW_CTRL_ADDR, 16'h0008);
    wr(PERIOD_LOW_ADDR, 16'hffff);
    wr(LOW_COUNT_ADDR, 16'h0000);
    wr(IRQ_FLAG_ADDR, 16'h0003);
    wr(HIGH_CTRL_ADDR, 16'h0040);
    wr(LOW_CTRL_ADDR, 16'h8048);
    ext.gate_window(30);
    repeat (10) @(posedge clk_i);
    c1 = low_count_o;
    repeat (20) @(posedge clk_i);
    check(low_count_o, c1, "count kept");
    check({15'h0000, c1 > 16'h0019 && c1 < 16'h0023}, 16'h0001, "gated span");
    rd(IRQ_FLAG_ADDR, 16'h0002, "gate fall flag");
    $display("test gate done");
    wr(LOW_CTRL_ADDR, 16'h0000);
    wr(PERIOD_HIGH_ADDR, 16'h0005);
    wr(HIGH_COUNT_ADDR, 16'h0000);
    wr(HIGH_CTRL_ADDR, 16'h8000);
    repeat (3) @(posedge clk_i);
    #1;
    check(high_count_o, 16'h0003, "high timer step");
    repeat (3) @(posedge clk_i);
    #1;
    check(high_count_o, 16'h0000, "high timer wrap");
    check({14'h0000, adc_trigger_o, high_match_o}, 16'h0003, "high match out");
    $display("test high done");
    rd(16'h0120, 16'h0000, "unmapped");
    wr(LOW_CTRL_ADDR, 16'hffff);
    rd(LOW_CTRL_ADDR, LOW_CTRL_MASK, "reserved bits");
    $display("test map done");
    complete_run();
  end
endmodule
